// ===== inc/uacb_pkg.sv
// Constants for the serial port control, frame format and baud block.
// Assumes a byte-wide register port and external shift engines.
// Notes on behaviour
// - Buffer-empty interrupt needs its enable, global enable and empty flag.
// - Receiver enable turns receiver on and takes over the receive pin.
// - Clearing receiver enable flushes buffer, clearing parity error flag and received ninth bit.
// - Transmitter enable turns transmitter on and drives the transmit pin.
// - Transmitter disable waits for empty shift register and buffer, then releases pin.
// - Three-bit size code: 000-011 give 5-8 bits, 111 nine, rest reserved.
// - Enhanced biphase mode ignores all character-size bits.
// - Received ninth or seventeenth bit readable; software reads it before low byte.
// - Writable bit sent as ninth or seventeenth; software writes it first.
// - Mode select 0 means asynchronous, 1 synchronous.
// - With parity on, transmitter appends parity; receiver checks and flags mismatch.
// - Parity field: 00 off, 01 reserved, 10 even, 11 odd.
// - Manchester enhanced mode has no parity; parity only for level coding.
// - Stop select gives transmitter one or two stop bits; receiver ignores it.
// - Enhanced mode: separate control sets receiver stop bits.
// - Sync polarity 0: send on rising, sample on falling; 1 swaps edges.
// - Twelve-bit divisor: high register four upper bits, low register eight lower.
// - Writing the low divisor register reloads the prescaler at once.
// - After reset the transmit buffer empty flag is set.
package uacb_pkg;

  localparam logic [2:0] REG_CTRL_B   = 3'h0;
  localparam logic [2:0] REG_FRAME    = 3'h1;
  localparam logic [2:0] REG_BAUD_LO  = 3'h2;
  localparam logic [2:0] REG_BAUD_HI  = 3'h3;
  localparam logic [2:0] REG_STATUS   = 3'h4;

  localparam int CB_RXC_IE_BIT  = 7;
  localparam int CB_TXC_IE_BIT  = 6;
  localparam int CB_TXE_IE_BIT  = 5;
  localparam int CB_RECEIVER_ENABLE_BIT    = 4;
  localparam int CB_TRANSMITTER_ENABLE_BIT    = 3;
  localparam int CB_CSZ_MSB_BIT = 2;
  localparam int CB_RX9_BIT     = 1;
  localparam int CB_TX9_BIT     = 0;

  localparam int FF_SYNC_BIT    = 6;
  localparam int FF_PAR_LSB     = 4;
  localparam int FF_STOP_BIT    = 3;
  localparam int FF_CSZ_LSB     = 1;
  localparam int FF_POL_BIT     = 0;

  localparam int ST_TXE_BIT     = 0;
  localparam int ST_PERR_BIT    = 1;
  localparam int ST_TXACT_BIT   = 2;
  localparam int ST_RSVD_SZ_BIT = 3;

  localparam logic [7:0]  CTRL_B_RST = 8'h00;
  localparam logic [7:0]  FRAME_RST  = 8'h00;
  localparam logic [11:0] BAUD_RST   = 12'h000;

  localparam logic [2:0] CSZ_9BIT = 3'h7;
  localparam logic [3:0] CHAR_BITS_BASE = 4'h5;

  typedef enum logic [1:0] {
    UACB_PAR_OFF  = 2'b00,
    UACB_PAR_RSVD = 2'b01,
    UACB_PAR_EVEN = 2'b10,
    UACB_PAR_ODD  = 2'b11
  } uacb_parity_e;

  typedef enum logic [1:0] {
    UACB_TX_OFF   = 2'b00,
    UACB_TX_ON    = 2'b01,
    UACB_TX_DRAIN = 2'b10
  } uacb_tx_state_e;

endpackage

// ===== verilog/uacb_ctrl.sv
// Control, frame format and baud prescaler of the serial port.
// Assumes external shift engines that report load, shift and receive events.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps

module uacb_ctrl (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic [2:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic [7:0]       rdata,
  input  wire logic        global_irq_enable,
  input  wire logic        enhanced_biphase_mode,
  input  wire logic        manchester_mode,
  input  wire logic        enhanced_rx_stop_select,
  input  wire logic        tx_data_write,
  input  wire logic        tx_load,
  input  wire logic        tx_shift_busy,
  input  wire logic [8:0]  tx_data,
  input  wire logic        rx_char_strobe,
  input  wire logic [8:0]  rx_data,
  input  wire logic        rx_parity_in,
  input  wire logic        rx_ninth_in,
  input  wire logic        rx_data_read,
  input  wire logic        sync_clock_pin,
  output logic             tx_empty_irq,
  output logic             tx_buffer_empty_flag,
  output logic             receiver_on,
  output logic             rx_pin_override,
  output logic             rx_flush,
  output logic             transmitter_on,
  output logic             transmit_pin_oe,
  output logic             tx_ninth_bit,
  output logic             rx_ninth_bit,
  output logic             parity_error_flag,
  output logic             tx_parity_bit,
  output logic [3:0]       char_bits,
  output logic             char_size_reserved,
  output logic             sync_mode,
  output logic             parity_on,
  output logic [1:0]       tx_stop_bits,
  output logic [1:0]       rx_stop_bits,
  output logic             baud_tick,
  output logic             tx_shift_strobe,
  output logic             rx_sample_strobe
);

  logic [7:0]                    ctrl_q;
  logic [7:0]                    frame_q;
  logic [11:0]                   baud_q;
  logic [3:0]                    baud_hi_pend_q;
  logic [11:0]                   presc_q;
  logic                          txe_q;
  logic                          rx9_q;
  logic                          perr_q;
  logic                          txpar_q;
  logic                          receiver_enable_prev_q;
  logic                          flush_q;
  logic                          xck_prev_q;
  logic [7:0]                    rdata_q;
  uacb_pkg::uacb_tx_state_e      tx_state_q;
  uacb_pkg::uacb_parity_e        par_mode;
  logic                          wr_ctrl;
  logic                          wr_lo;
  logic                          tx_idle;
  logic                          xck_rise;
  logic                          xck_fall;
  logic [2:0]                    csz_code;

  // Parity over the active data bits; odd sets the bit for an even count
  function automatic logic calc_parity(input logic [8:0] d, input logic [3:0] n,
                                       input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) begin
        p = p ^ d[i];
      end
    end
    return p;
  endfunction

  assign wr_ctrl  = wr_stb && (addr == uacb_pkg::REG_CTRL_B);
  assign wr_lo    = wr_stb && (addr == uacb_pkg::REG_BAUD_LO);
  assign par_mode = uacb_pkg::uacb_parity_e'(frame_q[uacb_pkg::FF_PAR_LSB +: 2]);
  assign csz_code = {ctrl_q[uacb_pkg::CB_CSZ_MSB_BIT], frame_q[uacb_pkg::FF_CSZ_LSB +: 2]};
  assign tx_idle  = txe_q && !tx_shift_busy;

  // Register writes; the read-only ninth bit is never stored from the bus
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_q  <= uacb_pkg::CTRL_B_RST;
      frame_q <= uacb_pkg::FRAME_RST;
    end else if (clk_en && wr_stb) begin
      unique case (addr)
        uacb_pkg::REG_CTRL_B: begin
          ctrl_q <= wdata & ~(8'h01 << uacb_pkg::CB_RX9_BIT);
        end
        uacb_pkg::REG_FRAME: begin
          frame_q <= wdata & 8'h7f;
        end
        default: begin
        end
      endcase
    end
  end

  // High part waits for the low write so a divisor never applies half-updated
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      baud_hi_pend_q <= uacb_pkg::BAUD_RST[11:8];
      baud_q         <= uacb_pkg::BAUD_RST;
    end else if (clk_en && wr_stb) begin
      if (addr == uacb_pkg::REG_BAUD_HI) begin
        baud_hi_pend_q <= wdata[3:0];
      end else if (addr == uacb_pkg::REG_BAUD_LO) begin
        baud_q <= {baud_hi_pend_q, wdata};
      end
    end
  end

  // Prescaler counts down and restarts on every low write
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      presc_q <= uacb_pkg::BAUD_RST;
    end else if (clk_en) begin
      if (wr_lo) begin
        presc_q <= {baud_hi_pend_q, wdata};
      end else if (presc_q == 12'h000) begin
        presc_q <= baud_q;
      end else begin
        presc_q <= presc_q - 12'h001;
      end
    end
  end

  assign baud_tick = clk_en && !wr_lo && (presc_q == 12'h000);

  // Buffer-empty flag: load by the shift engine wins over a data write
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      txe_q <= 1'b1;
    end else if (clk_en) begin
      if (tx_load) begin
        txe_q <= 1'b1;
      end else if (tx_data_write && txe_q) begin
        txe_q <= 1'b0;
      end
    end
  end

  // Parity captured with the character handed to the shift register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      txpar_q <= 1'b0;
    end else if (clk_en && tx_load) begin
      txpar_q <= calc_parity(tx_data, char_bits, par_mode == uacb_pkg::UACB_PAR_ODD);
    end
  end

  // Transmitter stays on after disable until nothing is left to send
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_state_q <= uacb_pkg::UACB_TX_OFF;
    end else if (clk_en) begin
      unique case (tx_state_q)
        uacb_pkg::UACB_TX_OFF: begin
          if (ctrl_q[uacb_pkg::CB_TRANSMITTER_ENABLE_BIT]) begin
            tx_state_q <= uacb_pkg::UACB_TX_ON;
          end
        end
        uacb_pkg::UACB_TX_ON: begin
          if (!ctrl_q[uacb_pkg::CB_TRANSMITTER_ENABLE_BIT]) begin
            tx_state_q <= uacb_pkg::UACB_TX_DRAIN;
          end
        end
        uacb_pkg::UACB_TX_DRAIN: begin
          if (ctrl_q[uacb_pkg::CB_TRANSMITTER_ENABLE_BIT]) begin
            tx_state_q <= uacb_pkg::UACB_TX_ON;
          end else if (tx_idle) begin
            tx_state_q <= uacb_pkg::UACB_TX_OFF;
          end
        end
        default: begin
          tx_state_q <= uacb_pkg::UACB_TX_OFF;
        end
      endcase
    end
  end

  // Receiver disable edge produces a one-cycle flush
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      receiver_enable_prev_q <= 1'b0;
      flush_q     <= 1'b0;
    end else if (clk_en) begin
      receiver_enable_prev_q <= ctrl_q[uacb_pkg::CB_RECEIVER_ENABLE_BIT];
      flush_q     <= receiver_enable_prev_q && !ctrl_q[uacb_pkg::CB_RECEIVER_ENABLE_BIT];
    end
  end

  // Receive-side flags: a new character wins over read or flush
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      perr_q <= 1'b0;
      rx9_q  <= 1'b0;
    end else if (clk_en) begin
      if (rx_char_strobe && ctrl_q[uacb_pkg::CB_RECEIVER_ENABLE_BIT]) begin
        rx9_q  <= rx_ninth_in;
        perr_q <= parity_on &&
                  (calc_parity(rx_data, char_bits, par_mode == uacb_pkg::UACB_PAR_ODD)
                   != rx_parity_in);
      end else if (flush_q || rx_data_read) begin
        perr_q <= 1'b0;
        rx9_q  <= 1'b0;
      end
    end
  end

  // Pin is sampled as a synchronous input; edges only matter in sync mode
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      xck_prev_q <= 1'b0;
    end else if (clk_en) begin
      xck_prev_q <= sync_clock_pin;
    end
  end

  assign xck_rise = clk_en && sync_clock_pin && !xck_prev_q;
  assign xck_fall = clk_en && !sync_clock_pin && xck_prev_q;

  always_comb begin
    if (sync_mode) begin
      tx_shift_strobe  = frame_q[uacb_pkg::FF_POL_BIT] ? xck_fall : xck_rise;
      rx_sample_strobe = frame_q[uacb_pkg::FF_POL_BIT] ? xck_rise : xck_fall;
    end else begin
      tx_shift_strobe  = baud_tick;
      rx_sample_strobe = baud_tick;
    end
  end

  // Character size decode; enhanced mode owns its own frame length
  always_comb begin
    char_bits          = 4'h0;
    char_size_reserved = 1'b0;
    if (!enhanced_biphase_mode) begin
      if (csz_code == uacb_pkg::CSZ_9BIT) begin
        char_bits = 4'h9;
      end else if (!csz_code[2]) begin
        char_bits = uacb_pkg::CHAR_BITS_BASE + {2'b00, csz_code[1:0]};
      end else begin
        char_size_reserved = 1'b1;
      end
    end
  end

  // Parity decode; the reserved code and Manchester coding in enhanced mode mean none
  always_comb begin
    unique case (par_mode)
      uacb_pkg::UACB_PAR_EVEN,
      uacb_pkg::UACB_PAR_ODD: begin
        parity_on = !(enhanced_biphase_mode && manchester_mode);
      end
      uacb_pkg::UACB_PAR_OFF,
      uacb_pkg::UACB_PAR_RSVD: begin
        parity_on = 1'b0;
      end
    endcase
  end

  assign sync_mode    = frame_q[uacb_pkg::FF_SYNC_BIT];
  assign tx_stop_bits = frame_q[uacb_pkg::FF_STOP_BIT] ? 2'h2 : 2'h1;
  assign rx_stop_bits = (enhanced_biphase_mode && enhanced_rx_stop_select)
                        ? 2'h2 : 2'h1;

  assign tx_empty_irq = ctrl_q[uacb_pkg::CB_TXE_IE_BIT] && global_irq_enable
                        && txe_q;
  assign tx_buffer_empty_flag = txe_q;
  assign receiver_on          = ctrl_q[uacb_pkg::CB_RECEIVER_ENABLE_BIT];
  assign rx_pin_override      = ctrl_q[uacb_pkg::CB_RECEIVER_ENABLE_BIT];
  assign rx_flush             = flush_q;
  assign transmitter_on       = tx_state_q != uacb_pkg::UACB_TX_OFF;
  assign transmit_pin_oe      = tx_state_q != uacb_pkg::UACB_TX_OFF;
  assign tx_ninth_bit         = ctrl_q[uacb_pkg::CB_TX9_BIT];
  assign rx_ninth_bit         = rx9_q;
  assign parity_error_flag    = perr_q;
  assign tx_parity_bit        = txpar_q;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      rdata_q <= 8'h00;
      if (rd_stb) begin
        unique case (addr)
          uacb_pkg::REG_CTRL_B: begin
            rdata_q <= ctrl_q | ({7'h00, rx9_q} << uacb_pkg::CB_RX9_BIT);
          end
          uacb_pkg::REG_FRAME: begin
            rdata_q <= frame_q;
          end
          uacb_pkg::REG_BAUD_LO: begin
            rdata_q <= baud_q[7:0];
          end
          uacb_pkg::REG_BAUD_HI: begin
            rdata_q <= {4'h0, baud_hi_pend_q};
          end
          uacb_pkg::REG_STATUS: begin
            rdata_q <= {4'h0, char_size_reserved, transmitter_on, perr_q, txe_q};
          end
          default: begin
            rdata_q <= 8'h00;
          end
        endcase
      end
    end
  end

  assign rdata = rdata_q;

endmodule

// ===== verif/uacb_ctrl_asserts.sv
// Port-level checks for the serial control block.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps

module uacb_ctrl_asserts (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       global_irq_enable,
  input wire logic       enhanced_biphase_mode,
  input wire logic       enhanced_rx_stop_select,
  input wire logic       tx_shift_busy,
  input wire logic       tx_empty_irq,
  input wire logic       tx_buffer_empty_flag,
  input wire logic       receiver_on,
  input wire logic       rx_pin_override,
  input wire logic       rx_flush,
  input wire logic       transmitter_on,
  input wire logic       transmit_pin_oe,
  input wire logic       rx_ninth_bit,
  input wire logic       parity_error_flag,
  input wire logic [3:0] char_bits,
  input wire logic       char_size_reserved,
  input wire logic       sync_mode,
  input wire logic [1:0] rx_stop_bits,
  input wire logic       baud_tick,
  input wire logic       tx_shift_strobe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Reset also drops the receiver; only a software disable counts
  sequence rx_off_s;
    $fell(receiver_on) && !$past(sys_rst);
  endsequence
  sequence flush_done_s;
    rx_flush ##1 (!rx_flush && !parity_error_flag && !rx_ninth_bit);
  endsequence

  irq_gate_a: assert property (
    tx_empty_irq |-> global_irq_enable && tx_buffer_empty_flag)
    else $error("buffer-empty interrupt without its conditions");
  rx_pin_a: assert property (rx_pin_override == receiver_on)
    else $error("receive pin override differs from receiver state");
  tx_pin_a: assert property (transmit_pin_oe == transmitter_on)
    else $error("transmit pin drive differs from transmitter state");
  tx_drain_a: assert property ($fell(transmit_pin_oe) && !$past(sys_rst) |->
    $past(tx_buffer_empty_flag) && !$past(tx_shift_busy))
    else $error("transmit pin released before buffers empty");
  rx_flush_a: assert property (rx_off_s |-> ##[0:1] flush_done_s)
    else $error("receiver disable did not flush");
  csz_zero_a: assert property (
    char_size_reserved || enhanced_biphase_mode |-> char_bits == 4'h0)
    else $error("character size not ignored");
  csz_range_a: assert property (!char_size_reserved && !enhanced_biphase_mode |->
    char_bits inside {[4'h5:4'h9]})
    else $error("character size out of range");
  rx_stop_a: assert property (rx_stop_bits ==
    ((enhanced_biphase_mode && enhanced_rx_stop_select) ? 2'h2 : 2'h1))
    else $error("receiver stop count wrong");
  async_tick_a: assert property (!sync_mode |-> tx_shift_strobe == baud_tick)
    else $error("asynchronous shift not on baud tick");
  reset_empty_a: assert property ($past(sys_rst) |-> tx_buffer_empty_flag)
    else $error("buffer empty flag clear after reset");
endmodule

bind uacb_ctrl uacb_ctrl_asserts chk_i (.mclk, .sys_rst, .global_irq_enable,
  .enhanced_biphase_mode, .enhanced_rx_stop_select, .tx_shift_busy, .tx_empty_irq,
  .tx_buffer_empty_flag, .receiver_on, .rx_pin_override, .rx_flush, .transmitter_on,
  .transmit_pin_oe, .rx_ninth_bit, .parity_error_flag, .char_bits, .char_size_reserved,
  .sync_mode, .rx_stop_bits, .baud_tick, .tx_shift_strobe);

// ===== verif/uacb_remote_node.sv
// Remote serial node: drives the synchronous clock pin.
// Assumes the bench asks for one pin edge per go pulse.
`timescale 1ns/1ps

module uacb_remote_node (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic go,
  output logic      sync_clock_pin
);
  // Clock stands still between requests, as outside a frame
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync_clock_pin <= 1'b0;
    end else if (go) begin
      sync_clock_pin <= ~sync_clock_pin;
    end
  end
endmodule

// ===== verif/uacb_ctrl_tb.sv
// Self-checking bench for the serial control block.
// Assumes 100 MHz mclk and the byte-wide register port.
`timescale 1ns/1ps

module uacb_ctrl_tb;
  logic mclk, sys_rst, clk_en, wr_stb, rd_stb, global_irq_enable, enhanced_biphase_mode;
  logic manchester_mode, enhanced_rx_stop_select, tx_data_write, tx_load, tx_shift_busy;
  logic rx_char_strobe, rx_parity_in, rx_ninth_in, rx_data_read, sync_clock_pin, go;
  logic tx_empty_irq, tx_buffer_empty_flag, receiver_on, rx_pin_override, rx_flush;
  logic transmitter_on, transmit_pin_oe, tx_ninth_bit, rx_ninth_bit, parity_error_flag;
  logic tx_parity_bit, char_size_reserved, sync_mode, parity_on, baud_tick;
  logic tx_shift_strobe, rx_sample_strobe;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [8:0] tx_data, rx_data;
  logic [3:0] char_bits;
  logic [1:0] tx_stop_bits, rx_stop_bits;
  int         fails, compares, n;
  logic [11:0] nt, nr;

  uacb_ctrl dut (.mclk, .sys_rst, .clk_en, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .global_irq_enable, .enhanced_biphase_mode, .manchester_mode, .enhanced_rx_stop_select,
    .tx_data_write, .tx_load, .tx_shift_busy, .tx_data, .rx_char_strobe, .rx_data,
    .rx_parity_in, .rx_ninth_in, .rx_data_read, .sync_clock_pin, .tx_empty_irq,
    .tx_buffer_empty_flag, .receiver_on, .rx_pin_override, .rx_flush, .transmitter_on,
    .transmit_pin_oe, .tx_ninth_bit, .rx_ninth_bit, .parity_error_flag, .tx_parity_bit,
    .char_bits, .char_size_reserved, .sync_mode, .parity_on, .tx_stop_bits, .rx_stop_bits,
    .baud_tick, .tx_shift_strobe, .rx_sample_strobe);
  uacb_remote_node peer (.mclk, .sys_rst, .go, .sync_clock_pin);

  always #5 mclk = ~mclk;

  task automatic chk(string nm, logic [11:0] got, logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [2:0] a);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  // One-cycle event pulse: 0 buffer write, 1 shift load, 2 char received, 3 pin edge
  task automatic ev(int k);
    @(posedge mclk);
    case (k)
      0: tx_data_write <= 1'b1;
      1: tx_load <= 1'b1;
      2: rx_char_strobe <= 1'b1;
      default: go <= 1'b1;
    endcase
    @(posedge mclk);
    {tx_data_write, tx_load, rx_char_strobe, go} <= 4'h0;
    #1;
  endtask
  task automatic gap();
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (!baud_tick && n < 600);
    if (n >= 600) begin
      fails++;
      wrap_up();
    end
  endtask

  initial begin
    {mclk, wr_stb, rd_stb, global_irq_enable, enhanced_biphase_mode, manchester_mode,
     enhanced_rx_stop_select, tx_data_write, tx_load, tx_shift_busy, rx_char_strobe,
     rx_parity_in, rx_ninth_in, rx_data_read, go} = '0;
    {addr, wdata, tx_data, rx_data} = '0;
    {fails, compares} = '0;
    clk_en = 1'b1;
    sys_rst = 1'b1;
    cyc(20);
    @(posedge mclk) sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(i[2:0]);
      chk("reset_reg", d, (i == 4) ? 12'h001 : 12'h000);
    end
    // Frozen block must ignore a write and a buffer event
    @(posedge mclk) clk_en <= 1'b0;
    wr(3'h0, 8'h08);
    ev(0);
    cyc(2);
    chk("frozen", {transmitter_on, tx_buffer_empty_flag}, 2'b01);
    @(posedge mclk) clk_en <= 1'b1;
    wr(3'h6, 8'hff);
    rd(3'h6);
    chk("unmapped", d, 12'h000);
    wr(3'h0, 8'h20);
    chk("irq_gie_off", tx_empty_irq, 1'b0);
    @(posedge mclk) global_irq_enable <= 1'b1;
    cyc(1);
    chk("irq_on", tx_empty_irq, 1'b1);
    ev(0);
    chk("irq_full", {tx_empty_irq, tx_buffer_empty_flag}, 2'b00);
    @(posedge mclk) tx_shift_busy <= 1'b1;
    wr(3'h0, 8'h08);
    cyc(2);
    chk("tx_on", {transmitter_on, transmit_pin_oe}, 2'b11);
    wr(3'h0, 8'h00);
    cyc(4);
    chk("tx_hold_buf", transmit_pin_oe, 1'b1);
    ev(1);
    cyc(3);
    chk("tx_hold_shift", transmit_pin_oe, 1'b1);
    @(posedge mclk) tx_shift_busy <= 1'b0;
    cyc(3);
    chk("tx_release", transmit_pin_oe, 1'b0);
    wr(3'h1, 8'h26);
    wr(3'h0, 8'h10);
    chk("rx_on", {receiver_on, rx_pin_override}, 2'b11);
    @(posedge mclk);
    rx_data <= 9'h001;
    rx_ninth_in <= 1'b1;
    ev(2);
    chk("rx_flags", {parity_error_flag, rx_ninth_bit}, 2'b11);
    rd(3'h0);
    chk("rx_ninth_rd", d, 12'h012);
    wr(3'h0, 8'h00);
    cyc(1);
    chk("rx_flush", rx_flush, 1'b1);
    cyc(2);
    chk("rx_flushed", {receiver_on, parity_error_flag, rx_ninth_bit}, 3'h0);
    @(posedge mclk);
    manchester_mode <= 1'b1;
    enhanced_biphase_mode <= 1'b1;
    // Wrong parity bit, so a live checker would flag it
    rx_parity_in <= 1'b1;
    wr(3'h0, 8'h10);
    ev(2);
    chk("manch_par", parity_error_flag, 1'b0);
    wr(3'h0, 8'h00);
    chk("enh_size", char_bits, 4'h0);
    @(posedge mclk);
    manchester_mode <= 1'b0;
    enhanced_biphase_mode <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      wr(3'h0, {5'h00, c[2], 2'h0});
      wr(3'h1, {5'h00, c[1:0], 1'b0});
      chk("char_bits", char_bits, (c < 4) ? 5 + c : (c == 7) ? 9 : 0);
      chk("char_rsvd", char_size_reserved, (c > 3 && c < 7));
    end
    wr(3'h0, 8'h00);
    @(posedge mclk) tx_data <= 9'h0b3;
    for (int p = 0; p < 4; p++) begin
      wr(3'h1, {2'h0, p[1:0], 4'h6});
      ev(1);
      chk("parity_on", parity_on, p[1]);
      if (p > 1) chk("tx_par", tx_parity_bit, (p == 2));
    end
    for (int s = 0; s < 2; s++) begin
      wr(3'h1, {4'h0, s[0], 3'h0});
      chk("stops", {tx_stop_bits, rx_stop_bits}, {s[1:0] + 2'h1, 2'h1});
    end
    @(posedge mclk);
    enhanced_biphase_mode <= 1'b1;
    enhanced_rx_stop_select <= 1'b1;
    cyc(1);
    chk("stops_enh", {tx_stop_bits, rx_stop_bits}, 4'ha);
    @(posedge mclk);
    enhanced_biphase_mode <= 1'b0;
    enhanced_rx_stop_select <= 1'b0;
    wr(3'h0, 8'h03);
    chk("tx_ninth", tx_ninth_bit, 1'b1);
    rd(3'h0);
    chk("rx_ninth_ro", d, 12'h001);
    for (int pol = 0; pol < 2; pol++) begin
      wr(3'h1, {7'h20, pol[0]});
      chk("sync", sync_mode, 1'b1);
      for (int e = 0; e < 2; e++) begin
        ev(3);
        {nt, nr} = '0;
        repeat (6) begin
          nt += tx_shift_strobe;
          nr += rx_sample_strobe;
          cyc(1);
        end
        chk("sync_tx", nt, (pol == e));
        chk("sync_rx", nr, (pol != e));
      end
    end
    wr(3'h1, 8'h00);
    wr(3'h3, 8'hf1);
    rd(3'h3);
    chk("baud_hi", d, 12'h001);
    chk("hi_pending", baud_tick, 1'b1);
    wr(3'h2, 8'h02);
    gap();
    chk("first_tick", n, 12'h102);
    gap();
    chk("tick_gap", n, 12'h103);
    rd(3'h2);
    chk("baud_lo", d, 12'h002);
    wrap_up();
  end
endmodule
